// ===== trc_pkg.sv
// Package for the reload/capture timer: register map, field positions, reset values.
// Assumes a 32-bit APB slave with one aligned word per register.
package trc_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] IDX_CONTROL = 8'hC8;   // Timer control
  localparam logic [7:0] IDX_RELOAD_LOW = 8'hCA;   // Reload low byte
  localparam logic [7:0] IDX_RELOAD_HIGH = 8'hCB;  // Reload high byte
  localparam logic [7:0] IDX_COUNT_LOW = 8'hCC;    // Count low byte
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hCD;   // Count high byte
  localparam logic [7:0] IDX_CLOCK_CTRL = 8'hCE;   // Per-byte clock selects
  localparam int ADDR_W = 12;                      // Byte address width

  // ****************************************************************
  // Control fields
  // ****************************************************************
  localparam int BIT_HIGH_OVF = 7;
  localparam int BIT_LOW_OVF = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_OSC_CAPTURE = 4;
  localparam int BIT_SPLIT = 3;
  localparam int BIT_RUN = 2;
  localparam int BIT_CAP_SRC = 1;
  localparam int BIT_EXT_TICK = 0;
  // Clock control fields
  localparam int BIT_HIGH_CLK_SEL = 1;
  localparam int BIT_LOW_CLK_SEL = 0;
  localparam int BIT_CAPTURE_MODE = 2;

  // ****************************************************************
  // Reset values and timing counts
  // ****************************************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int SYS_DIVIDE = 12;                  // System clock prescale
  localparam logic [3:0] PRESCALE_LAST = 4'(SYS_DIVIDE - 1);

  // Control bits carried as one packed group
  typedef struct packed {
    logic low_byte_irq_enable;
    logic osc_capture_enable;
    logic split_mode_select;
    logic run_control;
    logic capture_source_select;
    logic ext_tick_select;
  } trc_ctrl_t;

endpackage

// ===== trc_tick_gen.sv
// Tick generator: system clock divided by 12 and the synchronised external tick.
// Assumes the external divided clock is a slow level, asynchronous to CLK.
`timescale 1ns/100ps
module trc_tick_gen (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ext_clk_div8,
  input wire logic ext_tick_select,
  output logic slow_tick
);

  // ****************************************************************
  // Prescaler and synchroniser
  // ****************************************************************
  logic [3:0] presc_r;       // Divide-by-12 counter
  logic sync1_r;             // First synchroniser stage, read by sync2 only
  logic sync2_r;             // Second stage
  logic sync3_r;             // Delayed copy for edge detection
  logic div12_tick;

  // Free-running prescaler
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_r <= 4'h0;
    end else if (presc_r == trc_pkg::PRESCALE_LAST) begin
      presc_r <= 4'h0;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  assign div12_tick = (presc_r == trc_pkg::PRESCALE_LAST);

  // Two-flop synchroniser then edge register; keeps the counter on one clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
    end else begin
      sync1_r <= ext_clk_div8;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Rising edge becomes a one-cycle enable [R16]; select picks the slow tick [R8]
  assign slow_tick = ext_tick_select ? (sync2_r & ~sync3_r) : div12_tick;

endmodule

// ===== trc_timer.sv
// Top of the reload/capture timer: APB register file, counter, capture logic.
// Assumes a plain APB master; SOF and oscillator inputs synchronous to CLK.
// What this block does
// [R1] Low overflow interrupts when both enables set
// [R2] Oscillator capture enable selects oscillator capture
// [R3] Oscillator falling edge copies count to reload
// [R4] Split mode gives two auto-reload 8-bit timers
// [R5] Counting only while run control set
// [R6] Split mode: run gates high timer only
// [R7] Source select: 0 SOF, 1 oscillator edge
// [R8] External select: divide-12 or external/8
// [R9] Per-byte selects choose system clock or tick
// [R10] Reload low byte is read/write
// [R11] Reload high byte is read/write
// [R12] Count low reads low byte of counter
// [R13] 16-bit rollover reloads and sets high flag
// [R14] Low rollover sets low flag always
// [R15] Hardware never clears overflow flags
// [R16] External tick synchronised into one-cycle enable
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module trc_timer (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [trc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_IRQ_ENABLE,
  input wire logic EXT_CLK_DIV8,
  input wire logic USB_SOF,
  input wire logic LFO_OUT,
  output logic TIMER_IRQ
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  trc_pkg::trc_ctrl_t ctrl_r;     // Software control bits
  logic high_ovf_r;               // High overflow flag
  logic low_ovf_r;                // Low overflow flag
  logic [7:0] reload_lo_r;        // Reload / capture low byte
  logic [7:0] reload_hi_r;        // Reload / capture high byte
  logic [7:0] count_lo_r;         // Counter low byte
  logic [7:0] count_hi_r;         // Counter high byte
  logic high_clk_sel_r;           // 1: high timer on system clock
  logic low_clk_sel_r;            // 1: low timer on system clock
  logic capture_mode_r;           // General capture mode enable
  logic lfo_d_r;                  // Previous oscillator level
  logic capture_pulse_r;          // Capture happened, for interrupt
  logic slow_tick;
  logic tick_lo, tick_hi;
  logic run_lo, run_hi;
  logic inc_lo, inc_hi;
  logic wrap_lo, wrap_hi;
  logic lfo_fall, capture_evt;
  logic wr_en, rd_en;
  logic [7:0] word_idx;
  logic addr_ok;
  logic [7:0] rd_byte;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // Zero-wait slave; upper address bits must be zero for a hit
  assign word_idx = PADDR[9:2];
  assign addr_ok = (PADDR[1:0] == 2'b00) && (PADDR[trc_pkg::ADDR_W-1:10] == '0) &&
    ((word_idx == trc_pkg::IDX_CONTROL) || (word_idx == trc_pkg::IDX_RELOAD_LOW) ||
     (word_idx == trc_pkg::IDX_RELOAD_HIGH) || (word_idx == trc_pkg::IDX_COUNT_LOW) ||
     (word_idx == trc_pkg::IDX_COUNT_HIGH) || (word_idx == trc_pkg::IDX_CLOCK_CTRL));
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  // Only the low lane carries data; a write without lane 0 is ignored
  assign wr_en = PSEL & PENABLE & PWRITE & addr_ok & PSTRB[0];
  assign rd_en = PSEL & ~PENABLE & ~PWRITE;

  // ****************************************************************
  // Tick selection
  // ****************************************************************
  trc_tick_gen i_trc_tick_gen (
    .clk(CLK),
    .reset_n(RESET_N),
    .ext_clk_div8(EXT_CLK_DIV8),
    .ext_tick_select(ctrl_r.ext_tick_select),
    .slow_tick(slow_tick)
  );

  // Each byte: system clock or the selected slow tick [R9]
  assign tick_lo = low_clk_sel_r ? 1'b1 : slow_tick;
  assign tick_hi = high_clk_sel_r ? 1'b1 : slow_tick;

  // Low byte free-runs in split mode, run gates the rest [R5] [R6]
  assign run_lo = ctrl_r.split_mode_select ? 1'b1 : ctrl_r.run_control;
  assign run_hi = ctrl_r.run_control;

  // In 16-bit mode both bytes share the low byte's tick [R4]
  assign inc_lo = run_lo & tick_lo;
  assign wrap_lo = inc_lo & (count_lo_r == 8'hFF);
  assign inc_hi = ctrl_r.split_mode_select ? (run_hi & tick_hi) : wrap_lo;
  assign wrap_hi = inc_hi & (count_hi_r == 8'hFF);

  // ****************************************************************
  // Capture events
  // ****************************************************************
  assign lfo_fall = lfo_d_r & ~LFO_OUT;
  // Oscillator enable alone, or general mode with the source bit [R2] [R7]
  assign capture_evt = (ctrl_r.osc_capture_enable & lfo_fall) |
    (capture_mode_r & (ctrl_r.capture_source_select ? lfo_fall : USB_SOF));

  // Oscillator edge history
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lfo_d_r <= 1'b0;
      capture_pulse_r <= 1'b0;
    end else begin
      lfo_d_r <= LFO_OUT;
      capture_pulse_r <= capture_evt;
    end
  end

  // ****************************************************************
  // Control register
  // ****************************************************************
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_r <= '0;
      high_clk_sel_r <= 1'b0;
      low_clk_sel_r <= 1'b0;
      capture_mode_r <= 1'b0;
    end else if (wr_en && word_idx == trc_pkg::IDX_CONTROL) begin
      ctrl_r.low_byte_irq_enable <= PWDATA[trc_pkg::BIT_LOW_IRQ_EN];
      ctrl_r.osc_capture_enable <= PWDATA[trc_pkg::BIT_OSC_CAPTURE];
      ctrl_r.split_mode_select <= PWDATA[trc_pkg::BIT_SPLIT];
      ctrl_r.run_control <= PWDATA[trc_pkg::BIT_RUN];
      ctrl_r.capture_source_select <= PWDATA[trc_pkg::BIT_CAP_SRC];
      ctrl_r.ext_tick_select <= PWDATA[trc_pkg::BIT_EXT_TICK];
    end else if (wr_en && word_idx == trc_pkg::IDX_CLOCK_CTRL) begin
      high_clk_sel_r <= PWDATA[trc_pkg::BIT_HIGH_CLK_SEL];
      low_clk_sel_r <= PWDATA[trc_pkg::BIT_LOW_CLK_SEL];
      capture_mode_r <= PWDATA[trc_pkg::BIT_CAPTURE_MODE];
    end
  end

  // ****************************************************************
  // Overflow flags
  // ****************************************************************
  // Flags set by hardware; a control write loads them, hardware set wins [R15]
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      high_ovf_r <= 1'b0;
      low_ovf_r <= 1'b0;
    end else begin
      if (wrap_hi) begin
        high_ovf_r <= 1'b1; // [R13]
      end else if (wr_en && word_idx == trc_pkg::IDX_CONTROL) begin
        high_ovf_r <= PWDATA[trc_pkg::BIT_HIGH_OVF];
      end
      if (wrap_lo) begin
        low_ovf_r <= 1'b1; // [R14]
      end else if (wr_en && word_idx == trc_pkg::IDX_CONTROL) begin
        low_ovf_r <= PWDATA[trc_pkg::BIT_LOW_OVF];
      end
    end
  end

  // ****************************************************************
  // Reload registers
  // ****************************************************************
  // Capture beats a software write in the same cycle: the measurement matters more
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      reload_lo_r <= trc_pkg::RESET_BYTE;
      reload_hi_r <= trc_pkg::RESET_BYTE;
    end else if (capture_evt) begin
      reload_lo_r <= count_lo_r; // [R3]
      reload_hi_r <= count_hi_r; // [R3]
    end else begin
      if (wr_en && word_idx == trc_pkg::IDX_RELOAD_LOW) begin
        reload_lo_r <= PWDATA[7:0]; // [R10]
      end
      if (wr_en && word_idx == trc_pkg::IDX_RELOAD_HIGH) begin
        reload_hi_r <= PWDATA[7:0]; // [R11]
      end
    end
  end

  // ****************************************************************
  // Counter
  // ****************************************************************
  // Low byte; wraps to reload in split mode or at 16-bit rollover, else to zero. General capture mode keeps counting
  // through wrap to zero so the captured value is a raw period.
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_lo_r <= trc_pkg::RESET_BYTE;
    end else if (wr_en && word_idx == trc_pkg::IDX_COUNT_LOW) begin
      count_lo_r <= PWDATA[7:0];
    end else if (inc_lo) begin
      if (wrap_lo && ctrl_r.split_mode_select && !capture_mode_r) begin
        count_lo_r <= reload_lo_r; // [R4]
      end else if (wrap_lo && wrap_hi && !capture_mode_r) begin
        count_lo_r <= reload_lo_r; // [R13]
      end else begin
        count_lo_r <= count_lo_r + 8'h01;
      end
    end
  end

  // High byte
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      count_hi_r <= trc_pkg::RESET_BYTE;
    end else if (wr_en && word_idx == trc_pkg::IDX_COUNT_HIGH) begin
      count_hi_r <= PWDATA[7:0];
    end else if (inc_hi) begin
      if (wrap_hi && !capture_mode_r) begin
        count_hi_r <= reload_hi_r; // [R4] [R13]
      end else begin
        count_hi_r <= count_hi_r + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Interrupt output and read data
  // ****************************************************************
  // Level from the flags, plus a capture pulse [R1] [R3]
  assign TIMER_IRQ = TIMER_IRQ_ENABLE &
    (high_ovf_r | (ctrl_r.low_byte_irq_enable & low_ovf_r) | capture_pulse_r);

  // Read mux; unmapped reads give zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (word_idx)
      trc_pkg::IDX_CONTROL: rd_byte = {high_ovf_r, low_ovf_r, ctrl_r};
      trc_pkg::IDX_RELOAD_LOW: rd_byte = reload_lo_r;
      trc_pkg::IDX_RELOAD_HIGH: rd_byte = reload_hi_r;
      trc_pkg::IDX_COUNT_LOW: rd_byte = count_lo_r; // [R12]
      trc_pkg::IDX_COUNT_HIGH: rd_byte = count_hi_r;
      trc_pkg::IDX_CLOCK_CTRL: rd_byte = {5'h00, capture_mode_r, high_clk_sel_r,
        low_clk_sel_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data captured at setup so it stands through the access phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd_en) begin
      PRDATA <= addr_ok ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_low_wrap;
    wrap_lo;
  endsequence

  property p_low_flag;
    @(posedge CLK) disable iff (!RESET_N) s_low_wrap |=> low_ovf_r;
  endproperty
  a_low_flag: assert property (p_low_flag) else $error("low flag not set"); // [R14]

  property p_high_reload;
    @(posedge CLK) disable iff (!RESET_N)
      (wrap_hi && !ctrl_r.split_mode_select && !capture_mode_r && !wr_en) |=>
      (high_ovf_r && count_hi_r == $past(reload_hi_r) && count_lo_r == $past(reload_lo_r));
  endproperty
  a_high_reload: assert property (p_high_reload) else $error("no 16-bit reload"); // [R13]

  property p_flag_hold;
    @(posedge CLK) disable iff (!RESET_N) (high_ovf_r && !wr_en) |=> high_ovf_r;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hw"); // [R15]

  property p_capture;
    @(posedge CLK) disable iff (!RESET_N)
      capture_evt |=> (reload_lo_r == $past(count_lo_r) && reload_hi_r == $past(count_hi_r));
  endproperty
  a_capture: assert property (p_capture) else $error("capture lost"); // [R3]

  property p_stop;
    @(posedge CLK) disable iff (!RESET_N)
      (!ctrl_r.run_control && !ctrl_r.split_mode_select && !wr_en) |=> $stable(count_lo_r);
  endproperty
  a_stop: assert property (p_stop) else $error("counting while stopped"); // [R5]

  property p_split_hi_gate;
    @(posedge CLK) disable iff (!RESET_N)
      (ctrl_r.split_mode_select && !ctrl_r.run_control && !wr_en) |=> $stable(count_hi_r);
  endproperty
  a_split_hi_gate: assert property (p_split_hi_gate) else $error("high ran"); // [R6]

  property p_split_lo_run;
    @(posedge CLK) disable iff (!RESET_N)
      (ctrl_r.split_mode_select && low_clk_sel_r && !wr_en && count_lo_r != 8'hFF) |=>
      (count_lo_r == $past(count_lo_r) + 8'h01);
  endproperty
  a_split_lo_run: assert property (p_split_lo_run) else $error("low stalled"); // [R6]

  property p_irq_low;
    @(posedge CLK) disable iff (!RESET_N)
      (low_ovf_r && ctrl_r.low_byte_irq_enable && TIMER_IRQ_ENABLE) |-> TIMER_IRQ;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("low irq missing"); // [R1]

  property p_reload_wr;
    @(posedge CLK) disable iff (!RESET_N)
      (wr_en && word_idx == trc_pkg::IDX_RELOAD_LOW && !capture_evt) |=>
      (reload_lo_r == $past(PWDATA[7:0]));
  endproperty
  a_reload_wr: assert property (p_reload_wr) else $error("reload write lost"); // [R10]

endmodule

// ===== testbench.sv
// Self-checking bench for the reload/capture timer: register access, counting, capture.
// Assumes the APB slave answers with PREADY and the timer inputs are synchronous to CLK.
`timescale 1ns/100ps
module testbench;
  // ****************************************************************
  // Signals and register shorthands
  // ****************************************************************
  logic clk, rst_n, psel, penable, pwrite, irq_en, ext_clk, sof, lfo; // Driven inputs
  logic [trc_pkg::ADDR_W-1:0] paddr; // Byte address
  logic [31:0] pwdata, prdata, rdata; // Bus data and last read
  logic [3:0] pstrb; // Byte lanes
  logic pready, pslverr, irq, err; // Design outputs and last error
  int miscompares, compares, seen; // Counters
  logic [7:0] a, b; // Random bytes
  logic [7:0] ck, ct; // Mode table entries
  localparam logic [7:0] C_CTL = trc_pkg::IDX_CONTROL;
  localparam logic [7:0] C_RLL = trc_pkg::IDX_RELOAD_LOW;
  localparam logic [7:0] C_RLH = trc_pkg::IDX_RELOAD_HIGH;
  localparam logic [7:0] C_CNL = trc_pkg::IDX_COUNT_LOW;
  localparam logic [7:0] C_CNH = trc_pkg::IDX_COUNT_HIGH;
  localparam logic [7:0] C_CKC = trc_pkg::IDX_CLOCK_CTRL;
  // ****************************************************************
  // Design under test
  // ****************************************************************
  trc_timer i_trc_timer (.CLK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TIMER_IRQ_ENABLE(irq_en), .EXT_CLK_DIV8(ext_clk),
    .USB_SOF(sof), .LFO_OUT(lfo), .TIMER_IRQ(irq));
  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  // One APB transfer; an extra edge at the end keeps two requests from colliding
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) miscompares++;
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Compare and report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(rdata, {24'h000000, e});
  endtask
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Verdict, shared by the main sequence and the watchdog
  task automatic end_of_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog: the sequence needs about eight hundred cycles
  initial begin
    wait_c(20000);
    miscompares++;
    end_of_test();
  end
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {psel, penable, pwrite, irq_en, ext_clk, sof, lfo} = 7'h00;
    paddr = '0;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    rst_n = 1'b0;
    void'($urandom(38));
    wait_c(16);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, then an unmapped place
    rd(C_CTL, 8'h00);
    rd(C_RLL, 8'h00);
    rd(C_RLH, 8'h00);
    rd(C_CNL, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rdata, 32'h0);
    $display("test reset done");
    // Reload bytes read back, boundary values first
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
      b = ~a;
      wr(C_RLL, a);
      wr(C_RLH, b);
      rd(C_RLL, a);
      rd(C_RLH, b);
    end
    // A write without lane 0 must leave the register alone
    pstrb <= 4'hE;
    wr(C_RLL, ~a);
    pstrb <= 4'hF;
    rd(C_RLL, a);
    $display("test reload access done");
    // Run control off: counter holds even on the system clock
    wr(C_CKC, 8'h03);
    wr(C_CTL, 8'h00);
    a = 8'($urandom);
    wr(C_CNL, a);
    wait_c(30);
    rd(C_CNL, a);
    $display("test stopped done");
    // 16-bit rollover from near FFFF reloads 0x12xx and sets both flags
    wr(C_RLL, 8'h00);
    wr(C_RLH, 8'h12);
    wr(C_CNH, 8'hFF);
    wr(C_CNL, 8'hF0);
    irq_en <= 1'b1;
    wr(C_CTL, 8'h24);
    wait_c(30);
    // Flags are read while running: a control write of zero would clear them
    apb(1'b0, C_CTL, 8'h00);
    chk(rdata & 32'hC0, 32'hC0);
    chk({31'h0, irq}, 32'h1);
    wait_c(50);
    apb(1'b0, C_CTL, 8'h00);
    chk(rdata & 32'hC0, 32'hC0);
    wr(C_CTL, 8'h00);
    rd(C_CNH, 8'h12);
    // Keep only the low flag; its interrupt follows the low-byte enable
    wr(C_CTL, 8'h40);
    wait_c(2);
    chk({31'h0, irq}, 32'h0);
    wr(C_CTL, 8'h60);
    wait_c(2);
    chk({31'h0, irq}, 32'h1);
    wr(C_CTL, 8'h00);
    rd(C_CTL, 8'h00);
    $display("test overflow done");
    // External tick: five rising edges give exactly five counts
    wr(C_CKC, 8'h00);
    wr(C_CNL, 8'h00);
    wr(C_CNH, 8'h00);
    wr(C_CTL, 8'h05);
    repeat (5) begin
      ext_clk <= 1'b1;
      wait_c(6);
      ext_clk <= 1'b0;
      wait_c(6);
    end
    wait_c(8);
    wr(C_CTL, 8'h00);
    rd(C_CNL, 8'h05);
    // Divide by 12: prescaler phase and bus overhead leave a small window
    wr(C_CNL, 8'h00);
    wr(C_CTL, 8'h04);
    wait_c(120);
    wr(C_CTL, 8'h00);
    apb(1'b0, C_CNL, 8'h00);
    chk({31'h0, (rdata >= 32'd9 && rdata <= 32'd12)}, 32'h1);
    $display("test tick sources done");
    // Split mode with run off: low keeps wrapping to its reload, high holds
    wr(C_CKC, 8'h01);
    wr(C_RLL, 8'hF0);
    wr(C_CNL, 8'hF0);
    a = 8'($urandom);
    wr(C_CNH, a);
    wr(C_CTL, 8'h08);
    wait_c(100);
    apb(1'b0, C_CNL, 8'h00);
    chk({31'h0, rdata[7:0] >= 8'hF0}, 32'h1);
    rd(C_CNH, a);
    apb(1'b0, C_CTL, 8'h00);
    chk(rdata & 32'hC0, 32'h40);
    // Run on: high byte on the divide-12 tick wraps to its own reload
    wr(C_RLH, 8'h80);
    wr(C_CNH, 8'hFE);
    wr(C_CTL, 8'h0C);
    wait_c(60);
    apb(1'b0, C_CTL, 8'h00);
    chk(rdata & 32'h80, 32'h80);
    wr(C_CTL, 8'h00);
    apb(1'b0, C_CNH, 8'h00);
    chk({31'h0, (rdata >= 32'h80 && rdata <= 32'h85)}, 32'h1);
    $display("test split done");
    // Capture: oscillator enable, general mode on SOF, general mode on oscillator edge
    for (int k = 0; k < 3; k++) begin
      ck = (k == 0) ? 8'h03 : 8'h04;
      ct = (k == 0) ? 8'h10 : (k == 1) ? 8'h00 : 8'h02;
      a = 8'($urandom);
      b = 8'($urandom);
      wr(C_CNL, a);
      wr(C_CNH, b);
      wr(C_RLL, ~a);
      wr(C_RLH, ~b);
      wr(C_CKC, ck);
      wr(C_CTL, ct);
      if (k == 2) begin
        // SOF must be ignored while the oscillator edge is chosen
        sof <= 1'b1;
        @(posedge clk);
        sof <= 1'b0;
        wait_c(4);
        rd(C_RLL, ~a);
      end
      if (k == 1) begin
        sof <= 1'b1;
      end else begin
        lfo <= 1'b1;
        wait_c(3);
        lfo <= 1'b0;
      end
      @(posedge clk);
      sof <= 1'b0;
      seen = 0;
      repeat (8) begin
        @(posedge clk);
        if (irq === 1'b1) seen++;
      end
      chk(32'(seen), 32'h1);
      rd(C_RLL, a);
      rd(C_RLH, b);
    end
    $display("test capture done");
    end_of_test();
  end
endmodule
